// [src/ips_pkg.sv]
/*
 * Shared constants, enumerations and carrier structs of the interrogation
 * pulse sequencer: pulse timing in nanoseconds and derived clock counts,
 * mode and slot encodings, control and pulse bundles, state records.
 * Assumes a 125 MHz system clock; all cycle counts below derive from CLK_NS.
 */
// Function
// - All-call short and long: P4 leading edge 10.0 us after P1.
// - All-call short: P4 nominally 0.8 us wide.
// - All-call long at nominal: P4 1.6 us wide.
// - All-call short gives P1, P3 and short P4 only.
// - All-call long gives P1, P3 and long P4.
// - Legacy beacon interrogation gives only P1 and P3.
// - Mode S interrogation gives P1, P2 and P6.
// - Interlace: Mode S P1 follows preceding legacy P1 by 200 us.
// - Interlace ratio sets legacy interrogations before each Mode S one.
// - Double interrogation: second P1 200 us after first P1.
// - Each double slot independently picks legacy, Mode S, short or long all-call.
// - Double or burst without partner match flashes the pairing fault flag.
// - Burst command emits the programmed count of selected interrogations.
// - P6 off suppresses P6; nominal restores calibrated timing.
// - Signed width trim widens or narrows P6; nominal restores width.
// - Signed position trim shifts P6; nominal restores position.
// - P5 overlaps phase reversal; level follows partner SLS setting.
// - Phase reversal omitted when off, generated when on.
// - Phase reversal position trim moves reversal and P5 together.
// - P4 external setting follows partner level; P4 off suppresses P4.
// - All-call long applies signed width trim to P4.
// - All-call long applies signed position trim to P4.
// - Mode S: P2 2.0 us and P6 3.5 us after P1.
// - Phase reversal 2.75 us after P2 leading edge.
// - Legacy: P3 leading edge 8.0 us after P1.
package ips_pkg;

    // Clock and pulse timing in ns
    localparam int CLK_NS          = 8;
    localparam int PULSE_W_NS      = 800;
    localparam int P2_POS_NS       = 2000;
    localparam int P3_POS_NS       = 8000;
    localparam int P4_POS_NS       = 10000;
    localparam int P4_SHORT_NS     = 800;
    localparam int P4_LONG_NS      = 1600;
    localparam int P6_POS_NS       = 3500;
    localparam int P6_W_NS         = 16250;
    localparam int SPR_AFTER_P2_NS = 2750;
    localparam int SPR_W_NS        = 80;
    localparam int P5_W_NS         = 800;
    localparam int SLOT_NS         = 200000;
    localparam int FLASH_NS        = 250000000;

    // Derived cycle counts, least times rounded up
    localparam int PULSE_W_CYC  = (PULSE_W_NS + CLK_NS - 1) / CLK_NS;
    localparam int P2_POS_CYC   = (P2_POS_NS + CLK_NS - 1) / CLK_NS;
    localparam int P3_POS_CYC   = (P3_POS_NS + CLK_NS - 1) / CLK_NS;
    localparam int P4_POS_CYC   = (P4_POS_NS + CLK_NS - 1) / CLK_NS;
    localparam int P4_SHORT_CYC = (P4_SHORT_NS + CLK_NS - 1) / CLK_NS;
    localparam int P4_LONG_CYC  = (P4_LONG_NS + CLK_NS - 1) / CLK_NS;
    localparam int P6_POS_CYC   = (P6_POS_NS + CLK_NS - 1) / CLK_NS;
    localparam int P6_W_CYC     = (P6_W_NS + CLK_NS - 1) / CLK_NS;
    localparam int SPR_POS_CYC  = (P2_POS_NS + SPR_AFTER_P2_NS + CLK_NS - 1) / CLK_NS;
    localparam int SPR_W_CYC    = (SPR_W_NS + CLK_NS - 1) / CLK_NS;
    localparam int P5_W_CYC     = (P5_W_NS + CLK_NS - 1) / CLK_NS;
    localparam int P5_LEAD_CYC  = P5_W_CYC / 2;
    localparam int SLOT_CYC     = (SLOT_NS + CLK_NS - 1) / CLK_NS;
    localparam int FLASH_CYC    = FLASH_NS / CLK_NS;

    // Field widths
    localparam int T_W     = 16;
    localparam int TRIM_W  = 8;
    localparam int RATIO_W = 4;
    localparam int BURST_W = 16;
    localparam int FL_W    = 26;
    localparam int N_CH    = 7;

    // Window channel indices
    localparam int CH_P1  = 0;
    localparam int CH_P2  = 1;
    localparam int CH_P3  = 2;
    localparam int CH_P4  = 3;
    localparam int CH_P5  = 4;
    localparam int CH_P6  = 5;
    localparam int CH_SPR = 6;

    typedef enum logic [2:0] {
        legacy_beacon_mode        = 3'h0,
        uplink_message_mode       = 3'h1,
        all_call_short_mode       = 3'h3,
        all_call_long_mode        = 3'h2,
        interlace_mode            = 3'h6,
        double_interrogation_mode = 3'h7,
        burst_mode                = 3'h5
    } ips_mode_t;

    typedef enum logic [1:0] {
        KIND_LEGACY = 2'h0,
        KIND_UPLINK = 2'h1,
        KIND_SHORT  = 2'h3,
        KIND_LONG   = 2'h2
    } ips_kind_t;

    typedef enum logic [1:0] {
        PSEL_OFF = 2'h0,
        PSEL_CAL = 2'h1,
        PSEL_VAR = 2'h2
    } ips_psel_t;

    typedef enum logic {
        FSM_IDLE = 1'b0,
        FSM_RUN  = 1'b1
    } ips_fsm_t;

    typedef struct packed {
        logic                     nominal;
        logic signed [TRIM_W-1:0] value;
    } ips_trim_t;

    typedef struct packed {
        ips_mode_t          mode;
        ips_kind_t          slot1;
        ips_kind_t          slot2;
        logic [RATIO_W-1:0] ratio;
        ips_psel_t          p4_sel;
        ips_psel_t          p6_sel;
        logic               spr_on;
        logic               sls_enable;
        ips_trim_t          p4_width_trim;
        ips_trim_t          p4_position_trim;
        ips_trim_t          p6_width_trim;
        ips_trim_t          p6_position_trim;
        ips_trim_t          spr_position_trim;
    } ips_ctrl_t;

    typedef struct packed {
        logic p1;
        logic p2;
        logic p3;
        logic p4;
        logic p5;
        logic p6;
        logic spr;
        logic ext_level;
    } ips_pulse_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } ips_sync_t;

    typedef struct packed {
        ips_fsm_t           fsm;
        logic [T_W-1:0]     t;
        logic [RATIO_W:0]   slot;
        ips_kind_t          kind;
        logic [BURST_W-1:0] burst_left;
        logic [FL_W-1:0]    flash_cnt;
        logic               flash;
        logic               trig_prev;
        logic               busy;
        logic               burst_active;
        logic               fault;
        ips_pulse_t         pulses;
    } ips_state_t;

endpackage : ips_pkg

// [src/ips_sync.sv]
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to clock; output is a registered level.
 */
`timescale 1ns/1ps
module ips_sync
    import ips_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);

    ips_sync_t st_ff;
    ips_sync_t nxt_st;

    // Shift chain; level moves only when stages two and three agree
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = din;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        if (st_ff.s2 == st_ff.s3) begin
            nxt_st.level = st_ff.s3;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dout = st_ff.level;

endmodule : ips_sync

// [src/ips_window.sv]
/*
 * Pulse window comparator: high while the frame time lies in
 * [start, start + width). Purely combinational; caller registers the result.
 */
`timescale 1ns/1ps
module ips_window
    import ips_pkg::*;
(
    input  wire logic [T_W-1:0] t,
    input  wire logic [T_W-1:0] start,
    input  wire logic [T_W-1:0] width,
    input  wire logic           enable,
    output logic                hit
);

    logic [T_W:0] stop;

    // Widened end point avoids wrap at the top of the frame
    assign stop = {1'b0, start} + {1'b0, width};
    assign hit  = enable && (t >= start) && ({1'b0, t} < stop);

endmodule : ips_window

// [src/ips_sequencer.sv]
/*
 * Interrogation pulse sequencer top: schedules legacy, Mode S and all-call
 * interrogations, interlace and double groups and bursts, and draws the
 * pulse modulation lines with their trims.
 * Assumes control fields are static from front-panel logic on this clock,
 * the trigger and partner match come from pins, and burst_go is a one-cycle
 * pulse on this clock.
 */
`timescale 1ns/1ps
module ips_sequencer
    import ips_pkg::*;
#(
    parameter int SLOT_CYCLES  = SLOT_CYC,
    parameter int FLASH_CYCLES = FLASH_CYC
)(
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire ips_ctrl_t          ctrl,
    input  wire logic               trig_pin,
    input  wire logic               partner_match_pin,
    input  wire logic               burst_go,
    input  wire logic [BURST_W-1:0] burst_count,
    output ips_pulse_t              pulses,
    output logic                    seq_busy,
    output logic                    burst_active,
    output logic                    pairing_fault_flag
);

    localparam int CHK_P4S  = P4_SHORT_CYC;
    localparam int CHK_P4L  = P4_LONG_CYC;
    localparam int CHK_SPRW = SPR_W_CYC;

    // Refuse frame lengths the counters or the pulse layout cannot hold
    if (SLOT_CYCLES >= 2 ** T_W || SLOT_CYCLES < P6_POS_CYC + P6_W_CYC + 2 ** TRIM_W) begin : g_bad_slot
        $error("SLOT_CYCLES out of range");
    end
    if (FLASH_CYCLES >= 2 ** FL_W || FLASH_CYCLES < 2) begin : g_bad_flash
        $error("FLASH_CYCLES out of range");
    end

    ips_state_t         st_ff;
    ips_state_t         nxt_st;
    logic               trig_lvl;
    logic               match_lvl;
    logic               trig_rise;
    logic               fault_cond;
    logic [RATIO_W:0]   group_len;
    logic [T_W-1:0]     win_start [N_CH];
    logic [T_W-1:0]     win_width [N_CH];
    logic [N_CH-1:0]    win_en;
    logic [N_CH-1:0]    hit;
    logic signed [TRIM_W-1:0] p4w_eff;
    logic signed [TRIM_W-1:0] p4p_eff;
    logic signed [TRIM_W-1:0] p6w_eff;
    logic signed [TRIM_W-1:0] p6p_eff;
    logic signed [TRIM_W-1:0] sprp_eff;
    logic [T_W-1:0]     spr_start;

    // Pin inputs through the agreement synchroniser
    ips_sync u_trig_sync (
        .clock (clock),
        .rst_n (rst_n),
        .din   (trig_pin),
        .dout  (trig_lvl)
    );

    ips_sync u_match_sync (
        .clock (clock),
        .rst_n (rst_n),
        .din   (partner_match_pin),
        .dout  (match_lvl)
    );

    // Add a signed trim to a base time
    function automatic logic [T_W-1:0] add_trim(input logic [T_W-1:0] base,
                                                input logic signed [TRIM_W-1:0] tr);
        logic signed [T_W+1:0] sum;
        sum = $signed({2'b00, base}) + (T_W+2)'(tr);
        return sum[T_W-1:0];
    endfunction : add_trim

    // Interrogation type of a given slot of the current group
    function automatic ips_kind_t kind_for(input ips_ctrl_t c, input logic [RATIO_W:0] slot);
        ips_kind_t k;
        k = KIND_LEGACY;
        unique case (c.mode)
            legacy_beacon_mode:  k = KIND_LEGACY;
            uplink_message_mode: k = KIND_UPLINK;
            all_call_short_mode: k = KIND_SHORT;
            all_call_long_mode:  k = KIND_LONG;
            interlace_mode: begin
                k = (slot < group_len - 1'b1) ? KIND_LEGACY : KIND_UPLINK;
            end
            double_interrogation_mode: begin
                k = (slot == '0) ? c.slot1 : c.slot2;
            end
            burst_mode: k = c.slot1;
            default:    k = KIND_LEGACY;
        endcase
        return k;
    endfunction : kind_for

    // Group length; a zero ratio is served as one
    always_comb begin
        unique case (ctrl.mode)
            interlace_mode: begin
                group_len = (ctrl.ratio == '0) ? (RATIO_W+1)'(2)
                                               : {1'b0, ctrl.ratio} + 1'b1;
            end
            double_interrogation_mode: group_len = (RATIO_W+1)'(2);
            default:                   group_len = (RATIO_W+1)'(1);
        endcase
    end

    // Trims forced to zero at nominal; P4 trims only in long all-call
    assign p4w_eff  = (ctrl.p4_width_trim.nominal || st_ff.kind != KIND_LONG)
                      ? '0 : ctrl.p4_width_trim.value;
    assign p4p_eff  = (ctrl.p4_position_trim.nominal || st_ff.kind != KIND_LONG)
                      ? '0 : ctrl.p4_position_trim.value;
    assign p6w_eff  = ctrl.p6_width_trim.nominal ? '0 : ctrl.p6_width_trim.value;
    assign p6p_eff  = ctrl.p6_position_trim.nominal ? '0 : ctrl.p6_position_trim.value;
    assign sprp_eff = ctrl.spr_position_trim.nominal ? '0 : ctrl.spr_position_trim.value;
    assign spr_start = add_trim(T_W'(SPR_POS_CYC), sprp_eff);

    // Window layout of every pulse for the running interrogation type
    always_comb begin
        win_start[CH_P1] = '0;
        win_width[CH_P1] = T_W'(PULSE_W_CYC);
        win_en[CH_P1]    = 1'b1;
        win_start[CH_P2] = T_W'(P2_POS_CYC);
        win_width[CH_P2] = T_W'(PULSE_W_CYC);
        win_en[CH_P2]    = (st_ff.kind == KIND_UPLINK);
        win_start[CH_P3] = T_W'(P3_POS_CYC);
        win_width[CH_P3] = T_W'(PULSE_W_CYC);
        win_en[CH_P3]    = (st_ff.kind != KIND_UPLINK);
        win_start[CH_P4] = add_trim(T_W'(P4_POS_CYC), p4p_eff);
        win_width[CH_P4] = (st_ff.kind == KIND_LONG)
                           ? add_trim(T_W'(P4_LONG_CYC), p4w_eff)
                           : T_W'(P4_SHORT_CYC);
        win_en[CH_P4]    = ((st_ff.kind == KIND_SHORT) || (st_ff.kind == KIND_LONG))
                           && (ctrl.p4_sel != PSEL_OFF);
        win_start[CH_P5] = spr_start - T_W'(P5_LEAD_CYC);
        win_width[CH_P5] = T_W'(P5_W_CYC);
        win_en[CH_P5]    = (st_ff.kind == KIND_UPLINK) && ctrl.sls_enable;
        win_start[CH_P6] = add_trim(T_W'(P6_POS_CYC), p6p_eff);
        win_width[CH_P6] = add_trim(T_W'(P6_W_CYC), p6w_eff);
        win_en[CH_P6]    = (st_ff.kind == KIND_UPLINK) && (ctrl.p6_sel != PSEL_OFF);
        win_start[CH_SPR] = spr_start;
        win_width[CH_SPR] = T_W'(SPR_W_CYC);
        win_en[CH_SPR]    = (st_ff.kind == KIND_UPLINK) && ctrl.spr_on;
    end

    // One comparator per pulse line
    for (genvar ch = 0; ch < N_CH; ch++) begin : g_win
        ips_window u_win (
            .t      (st_ff.t),
            .start  (win_start[ch]),
            .width  (win_width[ch]),
            .enable (win_en[ch]),
            .hit    (hit[ch])
        );
    end

    assign trig_rise  = trig_lvl && !st_ff.trig_prev;
    assign fault_cond = ((ctrl.mode == double_interrogation_mode)
                         || (ctrl.mode == burst_mode)) && !match_lvl;

    // Sequencer, burst counter, flash timer and pulse registers
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.trig_prev = trig_lvl;

        // Burst load on command; count is spent one per trigger
        if (burst_go && ctrl.mode == burst_mode) begin
            nxt_st.burst_left = burst_count;
        end

        unique case (st_ff.fsm)
            FSM_IDLE: begin
                nxt_st.t = '0;
                if (trig_rise) begin
                    if (ctrl.mode != burst_mode) begin
                        nxt_st.fsm  = FSM_RUN;
                        nxt_st.slot = '0;
                        nxt_st.kind = kind_for(ctrl, '0);
                    end else if (st_ff.burst_left != '0 && !burst_go) begin
                        nxt_st.fsm        = FSM_RUN;
                        nxt_st.slot       = '0;
                        nxt_st.kind       = kind_for(ctrl, '0);
                        nxt_st.burst_left = st_ff.burst_left - 1'b1;
                    end
                end
            end
            FSM_RUN: begin
                nxt_st.t = st_ff.t + 1'b1;
                if (st_ff.t == T_W'(SLOT_CYCLES - 1)) begin
                    nxt_st.t = '0;
                    if (st_ff.slot + 1'b1 < group_len) begin
                        // Next interrogation 200 us after the previous P1
                        nxt_st.slot = st_ff.slot + 1'b1;
                        nxt_st.kind = kind_for(ctrl, st_ff.slot + 1'b1);
                    end else begin
                        nxt_st.fsm = FSM_IDLE;
                    end
                end
            end
        endcase

        // Pairing fault blinks while the mismatch stands
        if (fault_cond) begin
            if (st_ff.flash_cnt == FL_W'(FLASH_CYCLES - 1)) begin
                nxt_st.flash_cnt = '0;
                nxt_st.flash     = !st_ff.flash;
            end else begin
                nxt_st.flash_cnt = st_ff.flash_cnt + 1'b1;
            end
        end else begin
            nxt_st.flash_cnt = '0;
            nxt_st.flash     = 1'b0;
        end
        nxt_st.fault = fault_cond && !st_ff.flash;

        nxt_st.busy         = (nxt_st.fsm == FSM_RUN);
        nxt_st.burst_active = (nxt_st.burst_left != '0) || (ctrl.mode == burst_mode
                              && nxt_st.fsm == FSM_RUN);

        // Pulse lines registered from the windows
        nxt_st.pulses.p1  = st_ff.busy && hit[CH_P1];
        nxt_st.pulses.p2  = st_ff.busy && hit[CH_P2];
        nxt_st.pulses.p3  = st_ff.busy && hit[CH_P3];
        nxt_st.pulses.p4  = st_ff.busy && hit[CH_P4];
        nxt_st.pulses.p5  = st_ff.busy && hit[CH_P5];
        nxt_st.pulses.p6  = st_ff.busy && hit[CH_P6];
        nxt_st.pulses.spr = st_ff.busy && hit[CH_SPR];
        nxt_st.pulses.ext_level = st_ff.busy && ((hit[CH_P4] && ctrl.p4_sel == PSEL_VAR)
                                  || hit[CH_P5]);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pulses             = st_ff.pulses;
    assign seq_busy           = st_ff.busy;
    assign burst_active       = st_ff.burst_active;
    assign pairing_fault_flag = st_ff.fault;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // P4 leading edge sits at the all-call position with nominal trim
    chk_p4_lead_pos: assert property (
        $rose(pulses.p4) && ctrl.p4_position_trim.nominal |-> st_ff.t == T_W'(P4_POS_CYC + 1))
        else $error("P4 leading edge misplaced");

    // Short P4 lasts exactly its nominal width
    chk_p4_short_w: assert property (
        $rose(pulses.p4) && st_ff.kind == KIND_SHORT
        |-> ##(CHK_P4S - 1) pulses.p4 ##1 !pulses.p4)
        else $error("Short P4 width wrong");

    // Long P4 at nominal lasts exactly its nominal width
    chk_p4_long_w: assert property (
        $rose(pulses.p4) && st_ff.kind == KIND_LONG && ctrl.p4_width_trim.nominal
        |-> ##(CHK_P4L - 1) pulses.p4 ##1 !pulses.p4)
        else $error("Long P4 width wrong");

    // Legacy interrogation carries no P2, P4 or P6
    chk_legacy_only: assert property (
        st_ff.busy && st_ff.kind == KIND_LEGACY && $stable(st_ff.kind)
        |=> !pulses.p2 && !pulses.p4 && !pulses.p6)
        else $error("Extra pulse in legacy interrogation");

    // Mode S P2 leading edge follows P1 by the fixed spacing
    chk_p2_lead_pos: assert property (
        $rose(pulses.p2) |-> st_ff.t == T_W'(P2_POS_CYC + 1) && st_ff.kind == KIND_UPLINK)
        else $error("P2 leading edge misplaced");

    // P6 at nominal trim starts at its calibrated time
    chk_p6_nominal: assert property (
        $rose(pulses.p6) && $past(ctrl.p6_position_trim.nominal)
        |-> st_ff.t == T_W'(P6_POS_CYC + 1))
        else $error("P6 not at calibrated position");

    // P6 off keeps the line quiet
    chk_p6_off: assert property (
        ctrl.p6_sel == PSEL_OFF |=> !pulses.p6)
        else $error("P6 present while off");

    // Phase reversal absent when off, marker width exact when on
    chk_spr_off: assert property (
        !ctrl.spr_on |=> !pulses.spr)
        else $error("Phase reversal present while off");

    chk_spr_width: assert property (
        $rose(pulses.spr) |-> pulses.spr [*8] ##(CHK_SPRW - 9) pulses.spr [*2] ##1 !pulses.spr)
        else $error("Phase reversal marker width wrong");

    // P5 covers the phase reversal
    chk_p5_overlap: assert property (
        pulses.spr && ctrl.sls_enable && $stable(ctrl.sls_enable) |-> pulses.p5)
        else $error("P5 does not overlap phase reversal");

    // No fault flag without a pairing mismatch
    chk_fault_cause: assert property (
        pairing_fault_flag |-> $past(fault_cond))
        else $error("Pairing fault without cause");

    // Group slot never runs past the group length
    chk_group_len: assert property (
        st_ff.busy |-> st_ff.slot < group_len || $changed(ctrl.mode))
        else $error("Slot counter past group end");

    // All-call carries no P2, P5, P6 or reversal
    chk_allcall_only: assert property (
        st_ff.busy && (st_ff.kind == KIND_SHORT || st_ff.kind == KIND_LONG)
        && $stable(st_ff.kind)
        |=> !pulses.p2 && !pulses.p5 && !pulses.p6 && !pulses.spr)
        else $error("Extra pulse in all-call");

    // Mode S carries no P3 or P4
    chk_uplink_only: assert property (
        st_ff.busy && st_ff.kind == KIND_UPLINK && $stable(st_ff.kind)
        |=> !pulses.p3 && !pulses.p4)
        else $error("Extra pulse in Mode S");

    // P3 leading edge at its fixed spacing
    chk_p3_lead_pos: assert property (
        $rose(pulses.p3) |-> st_ff.t == T_W'(P3_POS_CYC + 1))
        else $error("P3 leading edge misplaced");

    // P4 off keeps the line quiet
    chk_p4_off: assert property (
        ctrl.p4_sel == PSEL_OFF |=> !pulses.p4)
        else $error("P4 present while off");

    // Reversal at nominal trim sits at its fixed time
    chk_spr_nominal: assert property (
        $rose(pulses.spr) && $past(ctrl.spr_position_trim.nominal)
        |-> st_ff.t == T_W'(SPR_POS_CYC + 1))
        else $error("Phase reversal misplaced");

endmodule : ips_sequencer

// [verif/ips_partner.sv]
/* Far-side test set model: trigger pulses and the pairing match level.
   Assumes requests arrive as one-cycle strobes on the system clock. */
`timescale 1ns/1ps
module ips_partner (
    input  wire logic clock,
    input  wire logic fire,
    input  wire logic match,
    output logic      trig_pin,
    output logic      partner_match_pin
);
    int hold = 0;
    // Trigger held high for 20 cycles per request
    always @(posedge clock) begin
        if (fire) hold <= 20;
        else if (hold > 0) hold <= hold - 1;
    end
    assign trig_pin = (hold > 0);
    assign partner_match_pin = match;
endmodule : ips_partner

// [verif/ips_sequencer_bench.sv]
/* Sequencer bench: sets controls, fires triggers through the partner, times pulse edges.
   Assumes shortened slot and flash counts; pulse times are relative to the P1 rise. */
`timescale 1ns/1ps
module ips_sequencer_bench;
    import ips_pkg::*;
    localparam int SC = 3000;
    logic               clock = 1'b0;
    logic               rst_n = 1'b0;
    logic               fire = 1'b0;
    logic               match = 1'b1;
    logic               burst_go = 1'b0;
    logic [BURST_W-1:0] burst_count = 16'h0000;
    ips_ctrl_t          ctrl = '0;
    ips_pulse_t         pulses;
    logic               trig_pin, partner_match_pin, seq_busy, burst_active, flag;
    int                 n_errors = 0, samples_checked = 0, tog;
    int                 first[8], last[8], nr[8], hi[8];
    always #4 clock = ~clock;
    ips_partner partner_u (.clock(clock), .fire(fire), .match(match), .trig_pin(trig_pin),
        .partner_match_pin(partner_match_pin));
    ips_sequencer #(.SLOT_CYCLES(SC), .FLASH_CYCLES(8)) dut_u (.clock(clock), .rst_n(rst_n),
        .ctrl(ctrl), .trig_pin(trig_pin), .partner_match_pin(partner_match_pin),
        .burst_go(burst_go), .burst_count(burst_count), .pulses(pulses), .seq_busy(seq_busy),
        .burst_active(burst_active), .pairing_fault_flag(flag));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %0d expected %0d", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // Fires nf triggers, records rise times, counts and high cycles per line
    task automatic measure(input int nf, input int win);
        logic [7:0] pv, pp;
        int t0;
        pp = 8'h00;
        t0 = -1;
        for (int b = 0; b < 8; b++) begin
            first[b] = -1; last[b] = -1; nr[b] = 0; hi[b] = 0;
        end
        for (int t = 0; t < win; t++) begin
            fire <= (t % (SC + 50) == 0) && (t / (SC + 50) < nf);
            @(posedge clock);
            #1;
            pv = pulses;
            if (pv[7] && !pp[7] && t0 < 0) t0 = t;
            for (int b = 0; b < 8; b++) begin
                if (pv[b] && !pp[b]) begin
                    nr[b]++;
                    last[b] = t - t0;
                    if (nr[b] == 1) first[b] = t - t0;
                end
                if (pv[b]) hi[b]++;
            end
            pp = pv;
        end
    endtask : measure
    initial begin
        ctrl.p4_sel = PSEL_CAL; ctrl.p6_sel = PSEL_CAL; ctrl.spr_on = 1'b1; ctrl.ratio = 4'h1;
        ctrl.sls_enable = 1'b1;
        repeat (20) @(posedge clock);
        #1 rst_n = 1'b1;
        measure(1, SC + 100);
        check(first[5], 1000);
        check(nr[6] + nr[4] + nr[2] + nr[1], 0);
        // Mode S with trims dialled but held at nominal
        ctrl.mode = uplink_message_mode;
        ctrl.p6_width_trim = 9'h105; ctrl.spr_position_trim = 9'h104;
        measure(1, SC + 100);
        check(first[6], 250);
        check(first[2], 438);
        check(first[1], 594);
        check(first[3], 544);
        check(hi[2], 2032);
        check(nr[5] + nr[4], 0);
        // Live trims on P6 and reversal
        ctrl.p6_width_trim = 9'h005; ctrl.p6_position_trim = 9'h0FD;
        ctrl.spr_position_trim = 9'h004;
        measure(1, SC + 100);
        check(hi[2], 2037);
        check(first[2], 435);
        check(first[1], 598);
        check(first[3], 548);
        ctrl.p6_sel = PSEL_OFF; ctrl.spr_on = 1'b0;
        measure(1, SC + 100);
        check(nr[2], 0);
        check(nr[1], 0);
        // All-call short
        ctrl.mode = all_call_short_mode;
        measure(1, SC + 100);
        check(first[4], 1250);
        check(hi[4], 100);
        check(nr[5] * 4 + nr[6] + nr[2], 4);
        // All-call long, externally levelled with trims, then nominal, then off
        ctrl.mode = all_call_long_mode; ctrl.p4_sel = PSEL_VAR;
        ctrl.p4_width_trim = 9'h008; ctrl.p4_position_trim = 9'h0FE;
        measure(1, SC + 100);
        check(hi[4], 208);
        check(first[4], 1248);
        check(hi[0], 208);
        ctrl.p4_sel = PSEL_CAL; ctrl.p4_width_trim = 9'h108; ctrl.p4_position_trim = 9'h1FE;
        measure(1, SC + 100);
        check(hi[4], 200);
        check(first[4] * 2 + nr[5], 2501);
        ctrl.p4_sel = PSEL_OFF;
        measure(1, SC + 100);
        check(nr[4], 0);
        // Interlace, two legacy then one Mode S
        ctrl.mode = interlace_mode; ctrl.ratio = 4'h2;
        measure(1, 3 * SC + 100);
        check(nr[7] * 4 + nr[6], 13);
        check(last[6] - 250, 2 * SC);
        check(seq_busy, 1'b0);
        // Double: short all-call then Mode S
        ctrl.mode = double_interrogation_mode; ctrl.slot1 = KIND_SHORT; ctrl.slot2 = KIND_UPLINK;
        ctrl.p4_sel = PSEL_CAL;
        measure(1, 2 * SC + 100);
        check(last[7], SC);
        check(nr[4] * 4 + nr[6], 5);
        check(flag, 1'b0);
        match = 1'b0;
        tog = 0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clock);
            #1;
            if (flag !== dut_u.pairing_fault_flag) tog = -99;
            if (i > 0 && flag !== last[0][0]) tog++;
            last[0] = flag;
        end
        check(tog > 2, 1'b1);
        match = 1'b1;
        repeat (10) @(posedge clock);
        #1;
        check(flag, 1'b0);
        // Burst of two legacy interrogations, third trigger refused
        ctrl.mode = burst_mode; ctrl.slot1 = KIND_LEGACY; burst_count = 16'h0002;
        burst_go = 1'b1;
        @(posedge clock);
        #1 burst_go = 1'b0;
        measure(3, 3 * (SC + 50) + 100);
        check(nr[7], 2);
        check(burst_active, 1'b0);
        finish_test();
    end
endmodule : ips_sequencer_bench
